/* logic/rdl_relay_ctrl.sv */
// relay driver load control: serial and parallel front ends, output latches
`timescale 1ns/1ps
module rdl_relay_ctrl (
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       clear_n_i,
  input  wire logic                       set_all_n_i,
  input  wire logic                       par_mode_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       sclk_i,
  input  wire logic                       sdi_i,
  output logic                            sdo_o,
  input  wire logic                       level_in_i,
  input  wire logic                       addr_bit0_i,
  input  wire logic                       addr_bit1_i,
  input  wire logic                       addr_bit2_i,
  output logic [rdl_pkg::DATA_W-1:0]      relay_o,
  output logic [rdl_pkg::DATA_W-1:0]      relay_oe_o,
  output logic                            frame_ready_o
);
  // ---------------------------------------------------------------------------
  // link domain: shift register on the serial clock
  // ---------------------------------------------------------------------------
  logic [rdl_pkg::DATA_W-1:0] shift_reg;
  logic [rdl_pkg::DATA_W-1:0] shift_next;
  logic                       sdo_reg;

  always_comb
  begin
    shift_next = shift_reg;
    if (!cs_n_i)
    begin
      shift_next = {shift_reg[rdl_pkg::DATA_W-2:0], sdi_i};
    end
  end

  always_ff @(posedge sclk_i or negedge clear_n_i)
  begin
    if (!clear_n_i)
    begin
      shift_reg <= rdl_pkg::RELAY_OFF;
    end
    else
    begin
      shift_reg <= shift_next;
    end
  end

  // falling edge so a cascaded part sees half a period of setup
  always_ff @(negedge sclk_i or negedge clear_n_i)
  begin
    if (!clear_n_i)
    begin
      sdo_reg <= 1'b0;
    end
    else
    begin
      sdo_reg <= shift_reg[rdl_pkg::DATA_W-1];
    end
  end

  assign sdo_o = sdo_reg;

  // ---------------------------------------------------------------------------
  // pin synchronisers: three stages, change taken once stages two and three agree
  // ---------------------------------------------------------------------------
  logic [rdl_pkg::PIN_W-1:0] pins_raw;
  logic [rdl_pkg::PIN_W-1:0] s1_reg;
  logic [rdl_pkg::PIN_W-1:0] s2_reg;
  logic [rdl_pkg::PIN_W-1:0] s3_reg;
  logic [rdl_pkg::PIN_W-1:0] filt_reg;
  logic [rdl_pkg::PIN_W-1:0] s1_next;
  logic [rdl_pkg::PIN_W-1:0] s2_next;
  logic [rdl_pkg::PIN_W-1:0] s3_next;
  logic [rdl_pkg::PIN_W-1:0] filt_next;
  logic                      cs_prev_reg;
  logic                      cs_prev_next;

  assign pins_raw = {par_mode_i, set_all_n_i, cs_n_i, level_in_i,
                     addr_bit2_i, addr_bit1_i, addr_bit0_i};

  always_comb
  begin
    s1_next      = sys_rst_i ? rdl_pkg::PIN_RST : pins_raw;
    s2_next      = sys_rst_i ? rdl_pkg::PIN_RST : s1_reg;
    s3_next      = sys_rst_i ? rdl_pkg::PIN_RST : s2_reg;
    cs_prev_next = sys_rst_i ? 1'b1 : filt_reg[rdl_pkg::PIN_CS];
  end

  genvar g;
  generate
    for (g = 0; g < rdl_pkg::PIN_W; g++)
    begin : g_filt
      assign filt_next[g] = sys_rst_i ? rdl_pkg::PIN_RST[g] :
                            (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : filt_reg[g];
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    s1_reg      <= s1_next;
    s2_reg      <= s2_next;
    s3_reg      <= s3_next;
    filt_reg    <= filt_next;
    cs_prev_reg <= cs_prev_next;
  end

  // ---------------------------------------------------------------------------
  // frame capture into the buffer
  // ---------------------------------------------------------------------------
  logic                         cs_rise;
  logic                         par_f;
  logic                         set_f;
  logic [rdl_pkg::ADDR_W-1:0]   addr_f;
  logic                         lvl_f;
  logic [rdl_pkg::DATA_W-1:0]   latch_reg;
  logic [rdl_pkg::DATA_W-1:0]   latch_next;

  rdl_stream_if #(.W(rdl_pkg::FRAME_W)) in_s ();
  rdl_stream_if #(.W(rdl_pkg::FRAME_W)) out_s ();

  assign par_f   = filt_reg[rdl_pkg::PIN_PAR];
  assign set_f   = filt_reg[rdl_pkg::PIN_SET];
  assign lvl_f   = filt_reg[rdl_pkg::PIN_LVL];
  assign addr_f  = filt_reg[rdl_pkg::PIN_ADDR_LSB +: rdl_pkg::ADDR_W];
  assign cs_rise = filt_reg[rdl_pkg::PIN_CS] && !cs_prev_reg;

  // shift_reg is quiet once select is high, so it is read only after the
  // synchronised rising edge; address and level ride the same pipeline
  assign in_s.valid = cs_rise;
  assign in_s.data  = par_f ?
                      {1'b1, 4'h0, lvl_f, addr_f} :
                      {1'b0, shift_reg};
  assign frame_ready_o = in_s.ready;

  // draining stalls while set-all is held; queued frames apply after it
  assign out_s.ready = set_f;

  rdl_fifo #(
    .W     (rdl_pkg::FRAME_W),
    .DEPTH (rdl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .clear_n_i (clear_n_i),
    .in_if     (in_s),
    .out_if    (out_s)
  );

  // ---------------------------------------------------------------------------
  // output latches
  // ---------------------------------------------------------------------------
  always_comb
  begin
    latch_next = latch_reg;
    if (sys_rst_i)
    begin
      latch_next = rdl_pkg::RELAY_OFF;
    end
    else if (!set_f)
    begin
      latch_next = rdl_pkg::RELAY_ALL_ON;
    end
    else if (out_s.valid)
    begin
      if (out_s.data[rdl_pkg::PAR_BIT])
      begin
        latch_next[out_s.data[rdl_pkg::ADDR_W-1:0]] = out_s.data[rdl_pkg::LVL_BIT];
      end
      else
      begin
        latch_next = out_s.data[rdl_pkg::DATA_W-1:0];
      end
    end
  end

  // clear is asynchronous and beats set-all and every frame
  always_ff @(posedge clk_i or negedge clear_n_i)
  begin
    if (!clear_n_i)
    begin
      latch_reg <= rdl_pkg::RELAY_OFF;
    end
    else
    begin
      latch_reg <= latch_next;
    end
  end

  // open drain: drive level is always the power return, enable follows the latch
  assign relay_o    = rdl_pkg::RELAY_OFF;
  assign relay_oe_o = latch_reg;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence clear_held_s;
    (!clear_n_i)[*2];
  endsequence

  sequence ser_push_s;
    cs_rise && !par_f && !out_s.valid && set_f && in_s.ready;
  endsequence

  sequence par_push_s;
    cs_rise && par_f && !out_s.valid && set_f && in_s.ready;
  endsequence

  property ser_apply_p;
    logic [rdl_pkg::DATA_W-1:0] w;
    disable iff (sys_rst_i || !clear_n_i)
    (ser_push_s, w = shift_reg) ##1 set_f |=> latch_reg == w;
  endproperty

  property par_apply_p;
    logic [rdl_pkg::ADDR_W-1:0] a;
    logic l;
    disable iff (sys_rst_i || !clear_n_i)
    (par_push_s, a = addr_f, l = lvl_f) ##1 set_f |=> latch_reg[a] == l;
  endproperty

  property par_keep_p;
    logic [rdl_pkg::ADDR_W-1:0] a;
    disable iff (sys_rst_i || !clear_n_i)
    (par_push_s, a = addr_f) ##1 set_f |=>
      ((latch_reg ^ $past(latch_reg)) & ~(8'h01 << a)) == 8'h00;
  endproperty

  clear_empties_a: assert property (clear_held_s |-> relay_oe_o == 8'h00)
    else $error("outputs not off under clear");
  clear_blocks_a: assert property ((!clear_n_i)[*3] |-> !out_s.valid && $stable(latch_reg))
    else $error("state moved while clear held");
  clear_over_set_a: assert property ((clear_held_s ##0 !set_all_n_i) |-> latch_reg == 8'h00)
    else $error("set-all beat clear");
  ser_apply_a: assert property (ser_apply_p)
    else $error("serial frame not applied two cycles after capture");
  par_apply_a: assert property (par_apply_p)
    else $error("addressed output did not take the level");
  par_keep_a: assert property (par_keep_p)
    else $error("unaddressed output changed");
  sink_only_a: assert property (relay_o == 8'h00 && relay_oe_o == latch_reg)
    else $error("relay pin not sinking per latch");
  shift_sample_a: assert property (@(posedge sclk_i) disable iff (!clear_n_i)
    !cs_n_i |=> shift_reg[0] == $past(sdi_i))
    else $error("serial bit not sampled");
  cascade_out_a: assert property (@(negedge sclk_i) disable iff (!clear_n_i)
    1'b1 |=> sdo_o == $past(shift_reg[rdl_pkg::DATA_W-1]))
    else $error("serial out not last stage");
endmodule

/* inc/rdl_pkg.sv */
// constants shared by the relay driver load control block
//
// Summary of operation
// - active-low clear empties the output latches, shift and serial-out registers and the buffer, so all relays switch off
// - clear overrides everything; no shifting, latching or set while it is low
// - clear and set-all low together: clear wins, all outputs stay off
// - serial: chip select low, sample serial data on each rising serial-clock edge
// - serial: chip select rising copies the shift register into the output latches
// - parallel: chip select rising captures address and level, applies level to output
// - serial data out shows last shift stage, updated on falling serial-clock edge
// - relay output sinks to power return when its bit is set, else floats
package rdl_pkg;

  // ---------------------------------------------------------------------------
  // widths and depths
  // ---------------------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 3;
  localparam int FRAME_W    = DATA_W + 1;
  localparam int FIFO_DEPTH = 8;

  // ---------------------------------------------------------------------------
  // frame word layout
  // ---------------------------------------------------------------------------
  localparam int PAR_BIT    = 8;
  localparam int LVL_BIT    = 3;

  // ---------------------------------------------------------------------------
  // synchronised pin vector layout and reset value
  // ---------------------------------------------------------------------------
  localparam int PIN_W        = 7;
  localparam int PIN_ADDR_LSB = 0;
  localparam int PIN_LVL      = 3;
  localparam int PIN_CS       = 4;
  localparam int PIN_SET      = 5;
  localparam int PIN_PAR      = 6;
  localparam logic [PIN_W-1:0] PIN_RST = 7'h30;

  // ---------------------------------------------------------------------------
  // output values
  // ---------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] RELAY_OFF    = 8'h00;
  localparam logic [DATA_W-1:0] RELAY_ALL_ON = 8'hFF;

endpackage

/* inc/rdl_stream_if.sv */
// valid/ready word stream between the control logic and its buffer
`timescale 1ns/1ps
interface rdl_stream_if #(
  parameter int W = rdl_pkg::FRAME_W
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* logic/rdl_fifo.sv */
// frame buffer: flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module rdl_fifo #(
  parameter int W     = rdl_pkg::FRAME_W,
  parameter int DEPTH = rdl_pkg::FIFO_DEPTH
) (
  input  wire logic  clk_i,
  input  wire logic  sys_rst_i,
  input  wire logic  clear_n_i,
  rdl_stream_if.snk  in_if,
  rdl_stream_if.src  out_if
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);

  logic [W-1:0]  mem_reg  [DEPTH];
  logic [W-1:0]  mem_next [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] wr_next;
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] rd_next;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign in_if.ready  = (cnt_reg != FULL);
  assign out_if.valid = (cnt_reg != '0);
  assign out_if.data  = mem_reg[rd_reg];
  assign push         = in_if.valid && in_if.ready;
  assign pop          = out_if.valid && out_if.ready;

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  always_comb
  begin
    mem_next = mem_reg;
    if (push)
    begin
      mem_next[wr_reg] = in_if.data;
    end
  end

  always_ff @(posedge clk_i)
  begin
    mem_reg <= mem_next;
  end

  // ---------------------------------------------------------------------------
  // pointers and fill count
  // ---------------------------------------------------------------------------
  always_comb
  begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (sys_rst_i)
    begin
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end
    else
    begin
      if (push)
      begin
        wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_next = cnt_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  // clear empties the buffer at once, whatever the clock does
  always_ff @(posedge clk_i or negedge clear_n_i)
  begin
    if (!clear_n_i)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

/* bench/rdl_host_model.sv */
// host model: drives the serial and parallel strobe pins
`timescale 1ns/1ps
module rdl_host_model (
  output logic       cs_n_o,
  output logic       sclk_o,
  output logic       sdi_o,
  output logic       lvl_o,
  output logic [2:0] addr_o
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
    lvl_o  = 1'b0;
    addr_o = 3'h0;
  end

  // link clock stands still outside frames
  task automatic ser(input logic [7:0] b);
    cs_n_o <= 1'b0;
    #16;
    for (int i = 7; i >= 0; i--)
    begin
      sdi_o <= b[i];
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
    end
    #16 cs_n_o <= 1'b1;
    #24 sdi_o <= ~sdi_o;
    #40;
  endtask

  // long hold: capture goes through synchronisers
  task automatic par(input logic [2:0] a, input logic l);
    addr_o <= a;
    lvl_o  <= l;
    cs_n_o <= 1'b0;
    #40 cs_n_o <= 1'b1;
    #40 addr_o <= ~a;
    lvl_o <= ~l;
    #40;
  endtask
endmodule

/* bench/tb.sv */
// self-checking bench for the relay driver load control block
`timescale 1ns/1ps
module tb;
  logic        clk_i;
  logic        sys_rst_i;
  logic        clear_n_i;
  logic        set_all_n_i;
  logic        par_mode_i;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic        lvl;
  logic [2:0]  addr;
  logic [7:0]  relay;
  logic [7:0]  relay_oe;
  logic        frame_ready;
  int          failures;
  int          check_count;
  logic [7:0]  exp_relay;
  logic [7:0]  b;
  logic [31:0] seed;
  logic [7:0]  fq [$];

  rdl_relay_ctrl u_dut (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .clear_n_i     (clear_n_i),
    .set_all_n_i   (set_all_n_i),
    .par_mode_i    (par_mode_i),
    .cs_n_i        (cs_n),
    .sclk_i        (sclk),
    .sdi_i         (sdi),
    .sdo_o         (sdo),
    .level_in_i    (lvl),
    .addr_bit0_i   (addr[0]),
    .addr_bit1_i   (addr[1]),
    .addr_bit2_i   (addr[2]),
    .relay_o       (relay),
    .relay_oe_o    (relay_oe),
    .frame_ready_o (frame_ready)
  );

  rdl_host_model u_host (
    .cs_n_o (cs_n),
    .sclk_o (sclk),
    .sdi_o  (sdi),
    .lvl_o  (lvl),
    .addr_o (addr)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // watchdog: the whole sequence needs about 10 us, so 100 us is ample
  initial
  begin
    #100000;
    failures++;
    finish_test();
  end

  initial
  begin
    sys_rst_i   = 1'b1;
    clear_n_i   = 1'b0;
    set_all_n_i = 1'b1;
    par_mode_i  = 1'b0;
    seed        = 32'hD8B0515F;
    failures    = 0;
    check_count = 0;
    exp_relay   = 8'h00;
    cyc(10);
    // clear too: only clear sets the link-side shift stage to a known value
    sys_rst_i <= 1'b0;
    clear_n_i <= 1'b1;
    cyc(10);
    chk8(relay_oe, 8'h00);
    // serial frames, edge values first
    for (int i = 0; i < 6; i++)
    begin
      b = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'(xs());
      u_host.ser(b);
      cyc(12);
      chk8(relay_oe, b);
      chk1(sdo, b[7]);
      chk8(relay, 8'h00);
    end
    $display("test serial done");
    exp_relay = b;
    @(posedge clk_i) par_mode_i <= 1'b1;
    cyc(8);
    for (int a = 0; a < 8; a++)
    begin
      b = 8'(xs());
      u_host.par(a[2:0], b[0]);
      exp_relay[a] = b[0];
      cyc(12);
      chk8(relay_oe, exp_relay);
    end
    $display("test parallel done");
    @(posedge clk_i) par_mode_i <= 1'b0;
    @(posedge clk_i) set_all_n_i <= 1'b0;
    cyc(8);
    // set-all stalls draining, so the buffer fills and the ninth frame is lost
    chk8(relay_oe, 8'hFF);
    for (int i = 0; i < 9; i++)
    begin
      b = 8'(xs());
      if (fq.size() < rdl_pkg::FIFO_DEPTH)
        fq.push_back(b);
      u_host.ser(b);
      if (i == 7)
      begin
        cyc(6);
        chk1(frame_ready, 1'b0);
      end
    end
    chk8(relay_oe, 8'hFF);
    @(posedge clk_i) set_all_n_i <= 1'b1;
    cyc(60);
    while (fq.size() > 0)
      exp_relay = fq.pop_front();
    chk8(relay_oe, exp_relay);
    chk1(frame_ready, 1'b1);
    $display("test buffer done");
    @(posedge clk_i) clear_n_i <= 1'b0;
    cyc(2);
    chk8(relay_oe, 8'h00);
    chk1(sdo, 1'b0);
    @(posedge clk_i) set_all_n_i <= 1'b0;
    u_host.ser(8'h5A);
    cyc(12);
    chk8(relay_oe, 8'h00);
    @(posedge clk_i) set_all_n_i <= 1'b1;
    cyc(8);
    @(posedge clk_i) clear_n_i <= 1'b1;
    cyc(12);
    chk8(relay_oe, 8'h00);
    u_host.ser(8'hC3);
    cyc(12);
    chk8(relay_oe, 8'hC3);
    $display("test clear done");
    finish_test();
  end
endmodule
